// ---- include/accdp_pkg.sv ----
/*
 * Shared constants and types of the accumulator add/AND datapath.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
`default_nettype none

package accdp_pkg;

	// Register byte offsets
	localparam logic [31:0] ADDR_CMD = 32'h0000_0000;
	localparam logic [31:0] ADDR_ACC = 32'h0000_0004;
	localparam logic [31:0] ADDR_FLAGS = 32'h0000_0008;
	localparam logic [31:0] ADDR_MPTR = 32'h0000_000c;
	localparam logic [31:0] ADDR_MDATA = 32'h0000_0010;

	// Command register fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_MADDR_LSB = 8;
	localparam int CMD_IMM_LSB = 16;

	// Flag positions in the flag register, and its width
	localparam int FLAG_C = 0;
	localparam int FLAG_HC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_W = 4;

	// Values after reset
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [3:0] FLAGS_RST = 4'h0;
	localparam logic [7:0] MEM_RST = 8'h00;

	// Size of a read's wait, in cycles of hclk
	localparam int READ_WAIT_CYC = 1;

	typedef enum logic [1:0] {
		ACCDP_OP_ADD_TO_MEM,
		ACCDP_OP_AND_MEM,
		ACCDP_OP_AND_IMM,
		ACCDP_OP_AND_TO_MEM
	} accdp_op_e;

	typedef enum logic [1:0] {
		ACCDP_BUS_IDLE,
		ACCDP_BUS_WRITE,
		ACCDP_BUS_READ_WAIT,
		ACCDP_BUS_READ_DONE
	} accdp_bus_e;

endpackage : accdp_pkg

`default_nettype wire

// ---- hdl/accdp_alu.sv ----
/*
 * Combinational arithmetic/logic unit: add and three AND forms.
 * Assumes operands are stable for the cycle in which an operation executes.
 */
`timescale 1ns/10ps
`default_nettype none

module accdp_alu (
	// Operation and operands
	input wire accdp_pkg::accdp_op_e op,
	input wire logic [7:0] acc_val,
	input wire logic [7:0] mem_val,
	input wire logic [7:0] imm_val,
	// Results
	output logic [7:0] result,
	output logic to_mem,
	output logic to_acc,
	output logic [accdp_pkg::FLAG_W-1:0] flags_val,
	output logic [accdp_pkg::FLAG_W-1:0] flags_mask
);

	logic [8:0] sum;
	logic [4:0] low_sum;

	assign sum = {1'b0, acc_val} + {1'b0, mem_val};
	assign low_sum = {1'b0, acc_val[3:0]} + {1'b0, mem_val[3:0]};

	always_comb begin
		result = 8'h00;
		to_mem = 1'b0;
		to_acc = 1'b0;
		flags_val = '0;
		flags_mask = '0;
		case (op)
			accdp_pkg::ACCDP_OP_ADD_TO_MEM: begin
				result = sum[7:0];
				to_mem = 1'b1;
				// Signed overflow: like-signed operands giving an unlike-signed sum
				flags_val[accdp_pkg::FLAG_OV] = (acc_val[7] == mem_val[7]) && (sum[7] != acc_val[7]);
				flags_val[accdp_pkg::FLAG_Z] = (sum[7:0] == 8'h00);
				flags_val[accdp_pkg::FLAG_HC] = low_sum[4];
				flags_val[accdp_pkg::FLAG_C] = sum[8];
				flags_mask = 4'hf;
			end
			accdp_pkg::ACCDP_OP_AND_MEM: begin
				result = acc_val & mem_val;
				to_acc = 1'b1;
				flags_val[accdp_pkg::FLAG_Z] = ((acc_val & mem_val) == 8'h00);
				flags_mask[accdp_pkg::FLAG_Z] = 1'b1;
			end
			accdp_pkg::ACCDP_OP_AND_IMM: begin
				result = acc_val & imm_val;
				to_acc = 1'b1;
				flags_val[accdp_pkg::FLAG_Z] = ((acc_val & imm_val) == 8'h00);
				flags_mask[accdp_pkg::FLAG_Z] = 1'b1;
			end
			accdp_pkg::ACCDP_OP_AND_TO_MEM: begin
				result = mem_val & acc_val;
				to_mem = 1'b1;
				flags_val[accdp_pkg::FLAG_Z] = ((mem_val & acc_val) == 8'h00);
				flags_mask[accdp_pkg::FLAG_Z] = 1'b1;
			end
			default: begin
				result = 8'h00;
			end
		endcase
	end

endmodule : accdp_alu

`default_nettype wire

// ---- hdl/accdp_mem.sv ----
/*
 * Data memory of flip-flops, one write port and two read ports.
 * Assumes a single write per cycle, chosen by the caller.
 */
`timescale 1ns/10ps
`default_nettype none

module accdp_mem #(
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	// Read ports
	input wire logic [AW-1:0] raddr_a,
	output logic [7:0] rdata_a,
	input wire logic [AW-1:0] raddr_b,
	output logic [7:0] rdata_b
);

	logic [7:0] mem_q [DEPTH];

	generate
		if (DEPTH != (1 << AW)) begin : g_bad_depth
			$error("accdp_mem: DEPTH must equal 2**AW");
		end
		for (genvar i = 0; i < DEPTH; i++) begin : g_entry
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					mem_q[i] <= accdp_pkg::MEM_RST;
				end else if (we && (waddr == AW'(i))) begin
					mem_q[i] <= wdata;
				end
			end
		end
	endgenerate

	assign rdata_a = mem_q[raddr_a];
	assign rdata_b = mem_q[raddr_b];

endmodule : accdp_mem

`default_nettype wire

// ---- hdl/accdp_top.sv ----
/*
 * Accumulator datapath slice with an AHB-Lite register slave.
 * Software loads operands, issues one operation per command write,
 * and reads back accumulator, flags and data memory.
 * Assumes one AHB-Lite master, hready fed back from hreadyout.
 */
// Register access over AHB-Lite and the placing of the registers were decided locally.
// Overview of operation
// - Add-to-memory: memory byte gets accumulator plus memory; accumulator kept.
// - Add-to-memory updates overflow, zero, half-carry and carry flags.
// - AND-with-memory: accumulator gets accumulator AND memory; zero flag only.
// - AND-with-immediate: accumulator gets accumulator AND immediate; zero flag only.
// - AND-to-memory forms memory byte AND accumulator.
`timescale 1ns/10ps
`default_nettype none

module accdp_top #(
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Datapath state
	output logic [7:0] accumulator,
	output logic overflow_flag,
	output logic zero_flag,
	output logic half_carry_flag,
	output logic carry_flag,
	output logic op_done
);

	generate
		if (AW < 1 || AW > 8) begin : g_bad_aw
			$error("accdp_top: AW must lie in 1..8");
		end
		if (DEPTH != (1 << AW)) begin : g_bad_depth
			$error("accdp_top: DEPTH must equal 2**AW");
		end
		if (accdp_pkg::FLAG_W != 4) begin : g_bad_flags
			$error("accdp_top: the flag register packs exactly four flags");
		end
		if (accdp_pkg::CMD_MADDR_LSB + AW > accdp_pkg::CMD_IMM_LSB) begin : g_bad_cmd
			$error("accdp_top: memory address field runs into the immediate");
		end
		if (accdp_pkg::READ_WAIT_CYC != 1) begin : g_bad_wait
			$error("accdp_top: the bus logic inserts exactly one read wait");
		end
	endgenerate

	// Bus state
	accdp_pkg::accdp_bus_e bus_q;
	accdp_pkg::accdp_bus_e bus_d;
	logic [31:0] addr_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;

	// Datapath state
	logic [7:0] acc_q;
	logic [accdp_pkg::FLAG_W-1:0] flags_q;
	logic [AW-1:0] mptr_q;
	logic done_q;

	// Decoded write of the current data phase
	logic wr_phase;
	logic wr_cmd;
	logic wr_acc;
	logic wr_flags;
	logic wr_mptr;
	logic wr_mdata;
	logic accept;

	// Command fields from the write data
	accdp_pkg::accdp_op_e cmd_op;
	logic [AW-1:0] cmd_maddr;
	logic [7:0] cmd_imm;

	// Datapath wiring
	logic [7:0] exec_mem_val;
	logic [7:0] bus_mem_val;
	logic [7:0] alu_result;
	logic alu_to_mem;
	logic alu_to_acc;
	logic [accdp_pkg::FLAG_W-1:0] alu_flags;
	logic [accdp_pkg::FLAG_W-1:0] alu_mask;
	logic mem_we;
	logic [AW-1:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic [31:0] read_val;

	// Address phase is taken only when the bus is ready and a transfer is requested
	assign accept = hsel && htrans[1] && hready;

	assign wr_phase = (bus_q == accdp_pkg::ACCDP_BUS_WRITE);
	assign wr_cmd = wr_phase && (addr_q == accdp_pkg::ADDR_CMD);
	assign wr_acc = wr_phase && (addr_q == accdp_pkg::ADDR_ACC);
	assign wr_flags = wr_phase && (addr_q == accdp_pkg::ADDR_FLAGS);
	assign wr_mptr = wr_phase && (addr_q == accdp_pkg::ADDR_MPTR);
	assign wr_mdata = wr_phase && (addr_q == accdp_pkg::ADDR_MDATA);

	// One command word both names the operation and starts it
	assign cmd_op = accdp_pkg::accdp_op_e'(hwdata[accdp_pkg::CMD_OP_LSB +: 2]);
	assign cmd_maddr = hwdata[accdp_pkg::CMD_MADDR_LSB +: AW];
	assign cmd_imm = hwdata[accdp_pkg::CMD_IMM_LSB +: 8];

	// Next bus state: any accepted address phase starts a data phase
	always_comb begin
		bus_d = accdp_pkg::ACCDP_BUS_IDLE;
		case (bus_q)
			accdp_pkg::ACCDP_BUS_READ_WAIT: begin
				bus_d = accdp_pkg::ACCDP_BUS_READ_DONE;
			end
			accdp_pkg::ACCDP_BUS_IDLE,
			accdp_pkg::ACCDP_BUS_WRITE,
			accdp_pkg::ACCDP_BUS_READ_DONE: begin
				if (accept && hwrite) begin
					bus_d = accdp_pkg::ACCDP_BUS_WRITE;
				end else if (accept) begin
					bus_d = accdp_pkg::ACCDP_BUS_READ_WAIT;
				end
			end
			default: begin
				bus_d = accdp_pkg::ACCDP_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_q <= accdp_pkg::ACCDP_BUS_IDLE;
		end else begin
			bus_q <= bus_d;
		end
	end

	// Captured only when an address phase is taken; held through its data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= 32'h0000_0000;
		end else if (accept && (bus_q != accdp_pkg::ACCDP_BUS_READ_WAIT)) begin
			addr_q <= haddr;
		end
	end

	// Reads wait one cycle so a write finishing on the same edge is seen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_q <= 1'b1;
		end else begin
			hreadyout_q <= (bus_d != accdp_pkg::ACCDP_BUS_READ_WAIT);
		end
	end

	// Only OKAY is ever answered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp_q <= 1'b0;
		end else begin
			hresp_q <= 1'b0;
		end
	end

	always_comb begin
		read_val = 32'h0000_0000;
		case (addr_q)
			// Commands are write-only; reading the command word gives zero
			accdp_pkg::ADDR_CMD: begin
				read_val = 32'h0000_0000;
			end
			accdp_pkg::ADDR_ACC: begin
				read_val = {24'h00_0000, acc_q};
			end
			accdp_pkg::ADDR_FLAGS: begin
				read_val = {28'h000_0000, flags_q};
			end
			accdp_pkg::ADDR_MPTR: begin
				read_val = {{(32 - AW){1'b0}}, mptr_q};
			end
			accdp_pkg::ADDR_MDATA: begin
				read_val = {24'h00_0000, bus_mem_val};
			end
			default: begin
				read_val = 32'h0000_0000;
			end
		endcase
	end

	// Held until the next read, so a master may pick it up late
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (bus_q == accdp_pkg::ACCDP_BUS_READ_WAIT) begin
			hrdata_q <= read_val;
		end
	end

	// Operand fetch and the single write port of data memory
	accdp_mem #(
		.DEPTH(DEPTH),
		.AW(AW)
	) u_mem (
		.clk(hclk),
		.rst_n(hresetn),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr_a(cmd_maddr),
		.rdata_a(exec_mem_val),
		.raddr_b(mptr_q),
		.rdata_b(bus_mem_val)
	);

	accdp_alu u_alu (
		.op(cmd_op),
		.acc_val(acc_q),
		.mem_val(exec_mem_val),
		.imm_val(cmd_imm),
		.result(alu_result),
		.to_mem(alu_to_mem),
		.to_acc(alu_to_acc),
		.flags_val(alu_flags),
		.flags_mask(alu_mask)
	);

	// A command and a memory-data write never share a data phase
	always_comb begin
		mem_we = 1'b0;
		mem_waddr = mptr_q;
		mem_wdata = hwdata[7:0];
		if (wr_cmd && alu_to_mem) begin
			mem_we = 1'b1;
			mem_waddr = cmd_maddr;
			mem_wdata = alu_result;
		end else if (wr_mdata) begin
			mem_we = 1'b1;
		end
	end

	// Accumulator changes only on AND into it or a direct write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_q <= accdp_pkg::ACC_RST;
		end else if (wr_cmd && alu_to_acc) begin
			acc_q <= alu_result;
		end else if (wr_acc) begin
			acc_q <= hwdata[7:0];
		end
	end

	// Only the flags an operation names change; the rest hold
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_q <= accdp_pkg::FLAGS_RST;
		end else if (wr_cmd) begin
			flags_q <= (flags_q & ~alu_mask) | (alu_flags & alu_mask);
		end else if (wr_flags) begin
			flags_q <= hwdata[accdp_pkg::FLAG_W-1:0];
		end
	end

	// Only the low AW bits are kept, so the pointer wraps within the memory
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mptr_q <= '0;
		end else if (wr_mptr) begin
			mptr_q <= hwdata[AW-1:0];
		end
	end

	// Back-to-back commands keep the strobe high for as many cycles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_q <= 1'b0;
		end else begin
			done_q <= wr_cmd;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign accumulator = acc_q;
	assign overflow_flag = flags_q[accdp_pkg::FLAG_OV];
	assign zero_flag = flags_q[accdp_pkg::FLAG_Z];
	assign half_carry_flag = flags_q[accdp_pkg::FLAG_HC];
	assign carry_flag = flags_q[accdp_pkg::FLAG_C];
	assign op_done = done_q;

endmodule : accdp_top

`default_nettype wire

// ---- bench/accdp_props.sv ----
/*
 * Concurrent checks of the accumulator datapath at the top module's ports.
 * Assumes hready is fed back from hreadyout and single word transfers only.
 */
`timescale 1ns/10ps
`default_nettype none

module accdp_props (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	// Datapath state
	input wire logic [7:0] accumulator,
	input wire logic overflow_flag,
	input wire logic zero_flag,
	input wire logic half_carry_flag,
	input wire logic carry_flag,
	input wire logic op_done
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic cmd_q;
	logic take;
	assign take = hsel && htrans[1] && hready;

	// Marks the data phase of a command write, when hwdata carries the op
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_q <= 1'b0;
		end else begin
			cmd_q <= take && hwrite && (haddr == accdp_pkg::ADDR_CMD);
		end
	end

	a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not OKAY");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
	a_done_pulse: assert property (op_done == $past(cmd_q)) else $error("op_done wrong");
	a_add_acc_kept: assert property (cmd_q && hwdata[1:0] == 2'h0 |=> $stable(accumulator))
		else $error("add changed accumulator");
	a_and_flags_kept: assert property (cmd_q && hwdata[1:0] != 2'h0 |=>
		$stable({overflow_flag, half_carry_flag, carry_flag})) else $error("AND changed flags");
	a_imm_result: assert property (cmd_q && hwdata[1:0] == 2'h2 |=>
		accumulator == ($past(accumulator) & $past(hwdata[23:16]))) else $error("AND imm wrong");
	a_imm_zero: assert property (cmd_q && hwdata[1:0] == 2'h2 |=>
		zero_flag == (accumulator == 8'h00)) else $error("AND imm zero flag wrong");
	a_tomem_acc_kept: assert property (cmd_q && hwdata[1:0] == 2'h3 |=> $stable(accumulator))
		else $error("AND to memory changed accumulator");
	a_and_mem_zero: assert property (cmd_q && hwdata[1:0] == 2'h1 |=>
		zero_flag == (accumulator == 8'h00)) else $error("AND memory zero flag wrong");

	c_read: cover property (take && !hwrite ##2 hreadyout);
	c_add: cover property (cmd_q && hwdata[1:0] == 2'h0);
	c_imm: cover property (cmd_q && hwdata[1:0] == 2'h2 ##1 zero_flag);
endmodule : accdp_props

bind accdp_top accdp_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .accumulator(accumulator),
	.overflow_flag(overflow_flag), .zero_flag(zero_flag), .half_carry_flag(half_carry_flag),
	.carry_flag(carry_flag), .op_done(op_done));

`default_nettype wire

// ---- bench/tb_accdp.sv ----
/*
 * Register-level testbench of the accumulator add/AND datapath.
 * Assumes the AHB-Lite map and command layout of the design package.
 */
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, ovf, zf, hcf, cf, done;
	logic [7:0] acc;
	logic [31:0] rv;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	// Add cases: accumulator, memory, sum, flags {ov, z, hc, c}
	logic [7:0] ta [4] = '{8'h7f, 8'hff, 8'h80, 8'h12};
	logic [7:0] tm [4] = '{8'h01, 8'h01, 8'h80, 8'h34};
	logic [7:0] ts [4] = '{8'h80, 8'h00, 8'h00, 8'h46};
	logic [3:0] tf [4] = '{4'ha, 4'h7, 4'hd, 4'h0};

	accdp_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .accumulator(acc),
		.overflow_flag(ovf), .zero_flag(zf), .half_carry_flag(hcf), .carry_flag(cf),
		.op_done(done));

	initial begin
		forever #10 hclk = ~hclk;
	end

	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One single transfer; hold each phase until hready is seen high
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask : xfer

	task wr(input logic [31:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task rd(input string nm, input logic [31:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, rv);
	endtask : rd

	always @(posedge hclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			wrap_up();
		end
	end

	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rd("acc reset", accdp_pkg::ADDR_ACC, 32'h0);
		rd("flags reset", accdp_pkg::ADDR_FLAGS, 32'h0);
		rd("mem reset", accdp_pkg::ADDR_MDATA, 32'h0);
		wr(32'h40, 32'h5a);
		rd("unmapped", 32'h40, 32'h0);
		wr(accdp_pkg::ADDR_MPTR, 32'h5);
		for (int i = 0; i < 4; i++) begin
			wr(accdp_pkg::ADDR_ACC, {24'h0, ta[i]});
			wr(accdp_pkg::ADDR_MDATA, {24'h0, tm[i]});
			wr(accdp_pkg::ADDR_CMD, 32'h0000_0500);
			@(posedge hclk);
			chk("done pulse", 32'h1, {31'h0, done});
			rd("add sum", accdp_pkg::ADDR_MDATA, {24'h0, ts[i]});
			rd("add acc", accdp_pkg::ADDR_ACC, {24'h0, ta[i]});
			rd("add flags", accdp_pkg::ADDR_FLAGS, {28'h0, tf[i]});
			chk("add acc pin", {24'h0, ta[i]}, {24'h0, acc});
			chk("add flag pins", {28'h0, tf[i]}, {28'h0, ovf, zf, hcf, cf});
		end
		// Preset the other flags so that a stray update is seen
		wr(accdp_pkg::ADDR_FLAGS, 32'hb);
		wr(accdp_pkg::ADDR_ACC, 32'hf0);
		@(posedge hclk);
		chk("no done", 32'h0, {31'h0, done});
		wr(accdp_pkg::ADDR_CMD, 32'h0000_0501);
		rd("and mem acc", accdp_pkg::ADDR_ACC, 32'h40);
		rd("and mem flags", accdp_pkg::ADDR_FLAGS, 32'hb);
		chk("and mem acc pin", 32'h40, {24'h0, acc});
		wr(accdp_pkg::ADDR_CMD, 32'h000f_0002);
		rd("and imm acc", accdp_pkg::ADDR_ACC, 32'h0);
		rd("and imm flags", accdp_pkg::ADDR_FLAGS, 32'hf);
		chk("and imm zero pin", 32'h1, {31'h0, zf});
		wr(accdp_pkg::ADDR_ACC, 32'h3c);
		wr(accdp_pkg::ADDR_CMD, 32'h0000_0503);
		rd("and to mem", accdp_pkg::ADDR_MDATA, 32'h04);
		rd("and to mem acc", accdp_pkg::ADDR_ACC, 32'h3c);
		rd("and to mem flags", accdp_pkg::ADDR_FLAGS, 32'hb);
		chk("hresp", 32'h0, {31'h0, hresp});
		wrap_up();
	end
endmodule : tb

`default_nettype wire
